/* core/stt_core.sv */
// Purpose: Timestamp counter kept in step by a shared sync pulse.
// Assumes: tb_tick_in is a synchronous one-cycle time-base tick.
// Notes:   Count and interrupt fields hold their value over reset.
`timescale 1ns/1ps

module stt_core
   import stt_pkg::*;
(
   input  logic              clk_in,
   input  logic              arst_n_in,
   input  logic              tb_tick_in,
   input  logic              sync_in,
   input  logic [1:0]        csr_idx_in,
   input  logic              csr_wr_in,
   input  logic              csr_rd_in,
   input  logic [63:0]       csr_wdata_in,
   output logic [63:0]       csr_rdata_out,
   output logic              csr_rvalid_out,
   output logic              sync_o_out,
   output logic              sync_oe_out,
   input  logic              link_x_in,
   input  logic              link_y_in,
   output logic              link_x_out,
   output logic              link_y_out,
   output logic              relay_o_out,
   output logic              relay_oe_out,
   output logic              intr_out,
   output logic [INUM_W-1:0] intr_num_out,
   output logic              intr_bus_out
);

   // -------------------------------------------------------------
   // Register decode
   // -------------------------------------------------------------
   logic wr_count;   // Count word written
   logic wr_agent;   // Agent config written
   logic wr_relay;   // Relay config written

   assign wr_count = csr_wr_in && (csr_idx_in == IDX_COUNT);
   assign wr_agent = csr_wr_in && (csr_idx_in == IDX_AGENT);
   assign wr_relay = csr_wr_in && (csr_idx_in == IDX_RELAY);

   // -------------------------------------------------------------
   // Sync pin edge
   // -------------------------------------------------------------
   logic sync_prev_q;  // Last sampled pin level
   logic sync_hit;     // Pulse start seen this cycle

   // The pin may stay high for several cycles; act once
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync_prev_q <= 1'b0;
      end else begin
         sync_prev_q <= sync_in;
      end
   end

   assign sync_hit = sync_in && !sync_prev_q;

   // -------------------------------------------------------------
   // Agent configuration
   // -------------------------------------------------------------
   logic              master_q;  // This agent generates the pulse
   stt_res_type       res_q;     // Resolution, off at reset
   logic              smode_q;   // Synchronising mode
   logic [INUM_W-1:0] inum_q;    // Interrupt number
   logic              iproc_q;   // Interrupt target bus

   // Master and resolution clear on reset
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         master_q <= 1'b0;
         res_q    <= RES_OFF;
      end else if (wr_agent) begin
         master_q <= csr_wdata_in[CFG_MAST];
         res_q    <= stt_res_type'(csr_wdata_in[CFG_RES +: 2]);
      end
   end

   // Sync mode: a pulse in the same cycle as a write wins
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         smode_q <= 1'b0;
      end else if (sync_hit) begin
         smode_q <= 1'b1;
      end else if (wr_agent) begin
         smode_q <= csr_wdata_in[CFG_SMODE];
      end
   end

   // Interrupt routing fields keep their value over reset
   always_ff @(posedge clk_in) begin
      if (wr_agent) begin
         inum_q  <= csr_wdata_in[CFG_INUM +: INUM_W];
         iproc_q <= csr_wdata_in[CFG_IPROC];
      end
   end

   // -------------------------------------------------------------
   // Relay configuration
   // -------------------------------------------------------------
   stt_src_type src_q;  // Incoming pulse source
   logic        xen_q;  // Forward to X link
   logic        yen_q;  // Forward to Y link

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         src_q <= SRC_NONE;
         xen_q <= 1'b0;
         yen_q <= 1'b0;
      end else if (wr_relay) begin
         src_q <= stt_src_type'(csr_wdata_in[RLY_SRC +: 2]);
         xen_q <= csr_wdata_in[RLY_XEN];
         yen_q <= csr_wdata_in[RLY_YEN];
      end
   end

   // -------------------------------------------------------------
   // Prescaler and timestamp count
   // -------------------------------------------------------------
   logic [PS_W-1:0] ps_q;  // Prescaler
   logic [PS_W-1:0] ps_d;
   logic [TS_W-1:0] ts_q;  // Timestamp count
   logic [TS_W-1:0] ts_d;
   logic            rounding;

   assign rounding = smode_q && sync_hit && (res_q != RES_OFF);

   // Rounding outranks a tick in the same cycle, so the agents
   // land on the same boundary; a count write outranks both
   always_comb begin
      ps_d = ps_q;
      ts_d = ts_q;
      if (!smode_q) begin
         ps_d = PS_ZERO;
      end else if (rounding) begin
         unique case (res_q)
            RES_OFF: ps_d = ps_q;
            RES_1US: ps_d = {PS_W{ps_q[PS_W-1]}};
            RES_2US: ps_d = {PS_W{ts_q[0]}};
            RES_4US: begin
               ps_d    = {PS_W{ts_q[1]}};
               ts_d[0] = ts_q[1];
            end
         endcase
      end else if (tb_tick_in) begin
         ps_d = ps_q + PS_ONE;
         if (ps_q == PS_TOP) begin
            ts_d = ts_q + TS_ONE;
         end
      end
      if (wr_count) begin
         ts_d = csr_wdata_in[TS_W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ps_q <= PS_ZERO;
      end else begin
         ps_q <= ps_d;
      end
   end

   // No reset: the count survives a reset untouched
   always_ff @(posedge clk_in) begin
      ts_q <= ts_d;
   end

   // -------------------------------------------------------------
   // Master pulse generator
   // -------------------------------------------------------------
   logic [7:0] gen_cnt_q;  // Ticks within the sync period

   // Counter idles at zero while not master
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         gen_cnt_q  <= GEN_ZERO;
         sync_o_out <= 1'b0;
      end else begin
         sync_o_out <= 1'b0;
         if (!master_q) begin
            gen_cnt_q <= GEN_ZERO;
         end else if (tb_tick_in) begin
            gen_cnt_q <= gen_cnt_q + GEN_ONE;
            if (gen_cnt_q == GEN_LAST) begin
               sync_o_out <= 1'b1;
            end
         end
      end
   end

   // Non-master agents leave the shared pin floating unless the relay source is a link
   assign sync_oe_out = master_q;

   // -------------------------------------------------------------
   // Checker and interrupt
   // -------------------------------------------------------------
   logic chk_err;  // One-cycle check failure

   stt_check u_check (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .tick_in   (tb_tick_in),
      .sync_in   (sync_hit),
      .res_in    (res_q),
      .err_out   (chk_err)
   );

   // Interrupt carries the number and bus chosen by software
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         intr_out     <= 1'b0;
         intr_num_out <= '0;
         intr_bus_out <= 1'b0;
      end else begin
         intr_out <= chk_err;
         if (chk_err) begin
            intr_num_out <= inum_q;
            intr_bus_out <= iproc_q;
         end
      end
   end

   // -------------------------------------------------------------
   // Relay
   // -------------------------------------------------------------
   stt_relay u_relay (
      .clk_in     (clk_in),
      .arst_n_in  (arst_n_in),
      .src_in     (src_q),
      .xen_in     (xen_q),
      .yen_in     (yen_q),
      .local_in   (sync_hit),
      .x_in       (link_x_in),
      .y_in       (link_y_in),
      .x_out      (link_x_out),
      .y_out      (link_y_out),
      .loc_out    (relay_o_out),
      .loc_oe_out (relay_oe_out)
   );

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   logic [63:0] rd_d;  // Word selected for reading

   // Unused bits and the spare index read as zero
   always_comb begin
      rd_d = RD_ZERO;
      case (csr_idx_in)
         IDX_COUNT: rd_d[TS_W-1:0] = ts_q;
         IDX_AGENT: begin
            rd_d[CFG_RES +: 2]       = res_q;
            rd_d[CFG_MAST]           = master_q;
            rd_d[CFG_SMODE]          = smode_q;
            rd_d[CFG_IPROC]          = iproc_q;
            rd_d[CFG_INUM +: INUM_W] = inum_q;
         end
         IDX_RELAY: begin
            rd_d[RLY_SRC +: 2] = src_q;
            rd_d[RLY_XEN]      = xen_q;
            rd_d[RLY_YEN]      = yen_q;
         end
         default: rd_d = RD_ZERO;
      endcase
   end

   // Read answer lands one cycle after the strobe
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         csr_rdata_out  <= RD_ZERO;
         csr_rvalid_out <= 1'b0;
      end else begin
         csr_rvalid_out <= csr_rd_in;
         if (csr_rd_in) begin
            csr_rdata_out <= rd_d;
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   sequence round_1us_s;
      rounding && res_q == RES_1US && !wr_agent;
   endsequence

   sequence round_4us_s;
      rounding && res_q == RES_4US && !wr_count;
   endsequence

   pin_master_only_a: assert property (sync_o_out |-> $past(master_q))
      else $error("sync pulse from non-master");
   gen_period_a: assert property (
      sync_o_out |-> $past(gen_cnt_q) == GEN_LAST && $past(tb_tick_in))
      else $error("sync pulse off period");
   hold_zero_a: assert property (!smode_q |=> ps_q == PS_ZERO)
      else $error("prescaler moved before first pulse");
   mode_set_a: assert property (sync_hit |=> smode_q)
      else $error("sync mode not set by pulse");
   count_step_a: assert property (
      smode_q && !rounding && tb_tick_in && ps_q == PS_TOP && !wr_count
      |=> ts_q - $past(ts_q) == TS_ONE)
      else $error("count did not advance");
   round_1us_a: assert property (
      round_1us_s |=> ps_q == PS_ZERO || ps_q == PS_TOP)
      else $error("prescaler not rounded");
   round_4us_a: assert property (
      round_4us_s |=> ts_q[1] == ts_q[0] && ps_q == {PS_W{ts_q[0]}})
      else $error("six-bit rounding wrong");
   count_write_a: assert property (
      wr_count |=> ts_q == $past(csr_wdata_in[TS_W-1:0]))
      else $error("count write lost");
   intr_route_a: assert property (
      chk_err |=> intr_out && intr_num_out == $past(inum_q)
      && intr_bus_out == $past(iproc_q))
      else $error("interrupt fields wrong");

endmodule : stt_core

/* core/stt_pkg.sv */
// Purpose: Shared constants for the synced timestamp counter.
// Assumes: Register bit 0 is the least significant bit.
// Notes:   Field positions are given as lsb indices.

package stt_pkg;

   // -------------------------------------------------------------
   // Widths and counts
   // -------------------------------------------------------------
   localparam int unsigned TS_W     = 48;       // Kept count bits
   localparam int unsigned PS_W     = 4;        // Prescaler bits
   localparam int unsigned CHK_W    = 9;        // Checker count
   localparam int unsigned INUM_W   = 6;        // Interrupt number
   localparam logic [3:0]  PS_TOP   = 4'hF;     // Carry value
   localparam logic [3:0]  PS_ZERO  = 4'h0;
   localparam logic [3:0]  PS_ONE   = 4'h1;
   localparam logic [7:0]  GEN_LAST = 8'hFF;    // 256 ticks a pulse
   localparam logic [7:0]  GEN_ZERO = 8'h00;
   localparam logic [7:0]  GEN_ONE  = 8'h01;
   localparam logic [47:0] TS_ONE   = 48'h0000_0000_0001;
   localparam logic [8:0]  PERIOD   = 9'h100;   // Sync period
   localparam logic [8:0]  TOL_1US  = 9'h007;
   localparam logic [8:0]  TOL_2US  = 9'h00F;
   localparam logic [8:0]  TOL_4US  = 9'h01F;
   localparam logic [8:0]  CNT_ZERO = 9'h000;
   localparam logic [8:0]  CNT_ONE  = 9'h001;
   localparam logic [8:0]  CNT_MAX  = 9'h1FF;

   // -------------------------------------------------------------
   // Register indices and field positions
   // -------------------------------------------------------------
   localparam logic [1:0]  IDX_COUNT = 2'h0;    // Timestamp count
   localparam logic [1:0]  IDX_AGENT = 2'h1;    // Agent config
   localparam logic [1:0]  IDX_RELAY = 2'h2;    // Relay config
   localparam int unsigned CFG_RES   = 0;       // Two bits
   localparam int unsigned CFG_MAST  = 2;
   localparam int unsigned CFG_SMODE = 3;
   localparam int unsigned CFG_IPROC = 4;
   localparam int unsigned CFG_INUM  = 5;       // Six bits
   localparam int unsigned RLY_YEN   = 0;
   localparam int unsigned RLY_XEN   = 1;
   localparam int unsigned RLY_SRC   = 2;       // Two bits
   localparam logic [63:0] RD_ZERO   = 64'h0000_0000_0000_0000;

   // Resolution codes
   typedef enum logic [1:0] {
      RES_OFF = 2'b00,
      RES_1US = 2'b01,
      RES_2US = 2'b10,
      RES_4US = 2'b11
   } stt_res_type;

   // Relay source codes
   typedef enum logic [1:0] {
      SRC_NONE  = 2'b00,
      SRC_LOCAL = 2'b01,
      SRC_XLINK = 2'b10,
      SRC_YLINK = 2'b11
   } stt_src_type;

endpackage : stt_pkg

/* core/stt_check.sv */
// Purpose: Sync interval checker, judged in time-base ticks.
// Assumes: Inputs are synchronous one-cycle pulses.
// Notes:   A missing pulse is flagged as soon as the window ends.
`timescale 1ns/1ps

module stt_check
   import stt_pkg::*;
(
   input  logic        clk_in,
   input  logic        arst_n_in,
   input  logic        tick_in,
   input  logic        sync_in,
   input  stt_res_type res_in,
   output logic        err_out
);

   logic [CHK_W-1:0] cnt_q;    // Ticks since last pulse
   logic             armed_q;  // A previous pulse was seen
   logic [CHK_W-1:0] tol;      // Half resolution in ticks, less one
   logic [CHK_W-1:0] lo;
   logic [CHK_W-1:0] hi;

   // Window edges per resolution
   always_comb begin
      unique case (res_in)
         RES_OFF: tol = CNT_ZERO;
         RES_1US: tol = TOL_1US;
         RES_2US: tol = TOL_2US;
         RES_4US: tol = TOL_4US;
      endcase
      lo = PERIOD - tol;
      hi = PERIOD + tol;
   end

   // Interval count and judgement
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q   <= CNT_ZERO;
         armed_q <= 1'b0;
         err_out <= 1'b0;
      end else begin
         err_out <= 1'b0;
         if (res_in == RES_OFF) begin
            cnt_q   <= CNT_ZERO;
            armed_q <= 1'b0;
         end else if (sync_in) begin
            err_out <= armed_q && ((cnt_q < lo) || (cnt_q > hi));
            armed_q <= 1'b1;
            cnt_q   <= CNT_ZERO;
         end else if (tick_in) begin
            // Late without a pulse: flag once, then wait to rearm
            if (armed_q && (cnt_q == hi)) begin
               err_out <= 1'b1;
               armed_q <= 1'b0;
            end
            if (cnt_q != CNT_MAX) begin
               cnt_q <= cnt_q + CNT_ONE;
            end
         end
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   chk_off_quiet_a: assert property (res_in == RES_OFF |=> !err_out)
      else $error("checker flagged while off");
   chk_early_a: assert property (
      sync_in && armed_q && res_in != RES_OFF && cnt_q < lo |=> err_out)
      else $error("early pulse not flagged");

endmodule : stt_check

/* core/stt_relay.sv */
// Purpose: Link agent relay of the sync pulse between nodes.
// Assumes: Link inputs are header flags, one cycle per packet.
// Notes:   Local source never loops back onto the local pin.
`timescale 1ns/1ps

module stt_relay
   import stt_pkg::*;
(
   input  logic        clk_in,
   input  logic        arst_n_in,
   input  stt_src_type src_in,
   input  logic        xen_in,
   input  logic        yen_in,
   input  logic        local_in,
   input  logic        x_in,
   input  logic        y_in,
   output logic        x_out,
   output logic        y_out,
   output logic        loc_out,
   output logic        loc_oe_out
);

   logic sel;     // Selected incoming pulse
   logic remote;  // Source is a link

   // Source selection
   always_comb begin
      unique case (src_in)
         SRC_NONE:  sel = 1'b0;
         SRC_LOCAL: sel = local_in;
         SRC_XLINK: sel = x_in;
         SRC_YLINK: sel = y_in;
      endcase
      remote = (src_in == SRC_XLINK) || (src_in == SRC_YLINK);
   end

   // Header flags out, and local drive for a remote source
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         x_out      <= 1'b0;
         y_out      <= 1'b0;
         loc_out    <= 1'b0;
         loc_oe_out <= 1'b0;
      end else begin
         x_out      <= sel && xen_in;
         y_out      <= sel && yen_in;
         loc_out    <= sel && remote;
         loc_oe_out <= remote;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   relay_x_gate_a: assert property (x_out |-> $past(xen_in) && $past(src_in) != SRC_NONE)
      else $error("x flag without enable");
   relay_y_src_a: assert property (
      src_in == SRC_YLINK && y_in && yen_in |=> y_out)
      else $error("y link pulse not forwarded");

endmodule : stt_relay

/* tb/stt_peer.sv */
// Purpose: Peer agents and incoming links around the timestamp block.
// Assumes: Bench raises each fire input for one clock cycle.
// Notes:   Peer master keeps off the sync pin while the block drives it.
`timescale 1ns/1ps

module stt_peer (
   input  wire logic fire_in,   // Peer master pulse request
   input  wire logic fx_in,     // Incoming X header flag request
   input  wire logic fy_in,     // Incoming Y header flag request
   input  wire logic dut_o_in,  // Block master drive value
   input  wire logic dut_oe_in, // Block master drive enable
   input  wire logic rly_o_in,  // Block relay drive value
   input  wire logic rly_oe_in, // Block relay drive enable
   output logic      pin_out,   // Resolved sync pin level
   output logic      lx_out,    // Flag seen in an X link header
   output logic      ly_out     // Flag seen in a Y link header
);
   // Block master and relay drives are ORed; the peer drives only when both are off
   assign pin_out = (dut_oe_in & dut_o_in) | (rly_oe_in & rly_o_in) |
                    (~dut_oe_in & ~rly_oe_in & fire_in);
   // Incoming packets carry the pulse as a header flag
   assign lx_out = fx_in;
   assign ly_out = fy_in;
endmodule // stt_peer

/* tb/stt_core_bench.sv */
// Purpose: Self-checking bench for the synced timestamp counter.
// Assumes: One tick every second clock; registers reached by index.
// Notes:   Intervals avoid window edges by a few ticks on purpose.
`timescale 1ns/1ps

module stt_core_bench;
   import stt_pkg::*;
   logic              clk_in = 1'b0, arst_n_in = 1'b0;      // Clock and reset
   logic              tick = 1'b0, fire = 1'b0, fx = 1'b0, fy = 1'b0;
   logic              wr = 1'b0, rd = 1'b0;                   // Register strobes
   logic [1:0]        idx = 2'h0;                             // Register index
   logic [63:0]       wd = 64'h0000_0000_0000_0000, rdat, got;
   logic              sync, lx, ly, rv, so, soe, xo, yo, ro, roe, intr, ibus;
   logic [INUM_W-1:0] inum;                                   // Interrupt number seen
   int                fail_count = 0, tests_run = 0, cyc = 0, nint = 0, nx = 0, ny = 0;
   int                gap = 0, last = 0, px, py, nr = 0, pr;  // Event counters

   stt_core dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .tb_tick_in(tick),
      .sync_in(sync), .csr_idx_in(idx), .csr_wr_in(wr), .csr_rd_in(rd),
      .csr_wdata_in(wd), .csr_rdata_out(rdat), .csr_rvalid_out(rv), .sync_o_out(so),
      .sync_oe_out(soe), .link_x_in(lx), .link_y_in(ly), .link_x_out(xo),
      .link_y_out(yo), .relay_o_out(ro), .relay_oe_out(roe), .intr_out(intr),
      .intr_num_out(inum), .intr_bus_out(ibus));
   stt_peer peer (.fire_in(fire), .fx_in(fx), .fy_in(fy), .dut_o_in(so),
      .dut_oe_in(soe), .rly_o_in(ro), .rly_oe_in(roe), .pin_out(sync),
      .lx_out(lx), .ly_out(ly));

   // 200 MHz clock
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end

   // Event counters and hang guard; gap counts ticks between master pulses
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (intr === 1'b1) nint <= nint + 1;
      if (xo === 1'b1) nx <= nx + 1;
      if (yo === 1'b1) ny <= ny + 1;
      if (ro === 1'b1) nr <= nr + 1;
      if (tick === 1'b1) gap <= gap + 1;
      if (so === 1'b1) begin
         last <= gap;
         gap <= 0;
      end
      if (cyc == 8000) begin
         fail_count++;
         end_of_test();
      end
   end

   // -------------------------------------------------------------
   // Access tasks
   // -------------------------------------------------------------
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task wrr(input logic [1:0] i, input logic [63:0] d);
      @(posedge clk_in);
      idx <= i;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   // Answer is valid the cycle after the taking edge
   task rdr(input logic [1:0] i);
      @(posedge clk_in);
      idx <= i;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 got = rdat;
      chk("rvalid", 64'h0000_0000_0000_0001, {63'h0, rv});
   endtask
   task tk(input int n);
      repeat (n) begin
         @(posedge clk_in);
         tick <= 1'b1;
         @(posedge clk_in);
         tick <= 1'b0;
      end
   endtask
   // Mask bit 0 local pin, bit 1 X header, bit 2 Y header
   task fs(input logic [2:0] m);
      @(posedge clk_in);
      fire <= m[0];
      fx <= m[1];
      fy <= m[2];
      @(posedge clk_in);
      fire <= 1'b0;
      fx <= 1'b0;
      fy <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_in);
      arst_n_in <= 1'b1;
      chk("pin oe", 64'h0, {63'h0, soe});
      rdr(IDX_AGENT);
      chk("agent", 64'h0, got & 64'h0000_0000_0000_000F);
      rdr(IDX_RELAY);
      chk("relay", 64'h0, got & 64'h0000_0000_0000_000F);
      rdr(2'h3);
      chk("unmapped", 64'h0, got);
      wrr(IDX_COUNT, 64'hFFFF_0000_0000_0100);
      rdr(IDX_COUNT);
      chk("count", 64'h0000_0000_0000_0100, got);
      tk(40);
      rdr(IDX_COUNT);
      chk("held", 64'h0000_0000_0000_0100, got);
      // 1 us resolution, interrupt number 2A to bus one
      wrr(IDX_AGENT, 64'h0000_0000_0000_0551);
      fs(3'h1);
      rdr(IDX_AGENT);
      chk("agent", 64'h0000_0000_0000_0559, got & 64'h0000_0000_0000_07FF);
      tk(40);
      rdr(IDX_COUNT);
      chk("count", 64'h0000_0000_0000_0102, got);
      tk(216);
      fs(3'h1);
      tk(252);
      fs(3'h1);
      tk(1);
      rdr(IDX_COUNT);
      chk("rounded", 64'h0000_0000_0000_0120, got);
      chk("no intr", 64'h0, 64'(nint));
      tk(240);
      fs(3'h1);
      chk("early", 64'h0000_0000_0000_0001, 64'(nint));
      chk("intr num", 64'h0000_0000_0000_002A, {58'h0, inum});
      chk("intr bus", 64'h0000_0000_0000_0001, {63'h0, ibus});
      wrr(IDX_AGENT, 64'h0000_0000_0000_0550);
      tk(100);
      fs(3'h1);
      chk("off", 64'h0000_0000_0000_0001, 64'(nint));
      // 4 us window accepts 280 ticks; first pulse is unjudged
      wrr(IDX_AGENT, 64'h0000_0000_0000_0553);
      fs(3'h1);
      tk(280);
      fs(3'h1);
      chk("wide", 64'h0000_0000_0000_0001, 64'(nint));
      // No pulse: flagged on the tick past 256 + 31
      tk(300);
      chk("late", 64'h0000_0000_0000_0002, 64'(nint));
      // 2 us: count low bit set lifts a low prescaler to F
      wrr(IDX_AGENT, 64'h0000_0000_0000_0552);
      wrr(IDX_COUNT, 64'h0000_0000_0000_0000);
      fs(3'h1);
      tk(244);
      fs(3'h1);
      tk(1);
      rdr(IDX_COUNT);
      chk("2us round", 64'h0000_0000_0000_0010, got);
      chk("2us window", 64'h0000_0000_0000_0002, 64'(nint));
      // Mid-run reset keeps the count and interrupt routing
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
      rdr(IDX_COUNT);
      chk("kept", 64'h0000_0000_0000_0010, got);
      rdr(IDX_AGENT);
      chk("agent rst", 64'h0000_0000_0000_0550, got & 64'h0000_0000_0000_07FF);
      wrr(IDX_AGENT, 64'h0000_0000_0000_0550);
      // Every source; source 3 keeps only the Y output enabled
      for (int s = 0; s < 4; s++) begin
         wrr(IDX_RELAY, 64'(s * 4 + ((s == 3) ? 1 : 3)));
         px = nx;
         py = ny;
         pr = nr;
         fs((s == 0) ? 3'h7 : 3'(1 << (s - 1)));
         chk("link x", 64'(s == 1 || s == 2), 64'(nx - px));
         chk("link y", 64'(s != 0), 64'(ny - py));
         chk("relay o", 64'(s >= 2), 64'(nr - pr));
         chk("relay oe", 64'(s >= 2), {63'h0, roe});
      end
      // All agents set up before the master is enabled
      wrr(IDX_AGENT, 64'h0000_0000_0000_0554);
      tk(600);
      chk("master oe", 64'h0000_0000_0000_0001, {63'h0, soe});
      chk("period", 64'h0000_0000_0000_0100, 64'(last));
      end_of_test();
   end
endmodule // stt_core_bench
